// ===== src/mpca_button.sv
// Pushbutton synchroniser and debouncer giving one pulse per press.
module mpca_button #(
  parameter int CYCLES = mpca_pkg::DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic btn,
  output logic press
);

  localparam int CW = $clog2(CYCLES + 1);

  logic sync1_q, sync2_q, stable_q, press_q;
  logic stable_d, press_d;
  logic [CW-1:0] cnt_q, cnt_d;

  // A level must hold for the whole count before it is believed, so
  // contact bounce on either edge produces no extra pulse.
  always_comb begin
    stable_d = stable_q;
    press_d = 1'b0;
    cnt_d = cnt_q;
    if (sync2_q == stable_q) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(CYCLES - 1)) begin
      cnt_d = '0;
      stable_d = sync2_q;
      press_d = sync2_q;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      stable_q <= 1'b0;
      press_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      sync1_q <= btn;
      sync2_q <= sync1_q;
      stable_q <= stable_d;
      press_q <= press_d;
      cnt_q <= cnt_d;
    end
  end

  assign press = press_q;

endmodule : mpca_button

// ===== src/mpca_panel.sv
// Maintenance panel: lamp selection, character load and panel core access.
// What this block does
// - Route selected register to the address lamps.
// - Data lamps show character pair directly or the view route bus.
// - Lamps light only while the central logic is halted.
// - Each selector position shows a fixed register set.
// - Load button ORs data switches with view route bus into character.
// - Base character position gates nothing onto the view route bus.
// - Character load is accepted whenever the central logic is halted.
// - System reset clears registers, counters land in switch step two.
// - Positioning function is 1111, address load step is 0100.
// - Sub-step zero idles, sub-steps one to four load digits top first.
// - After sub-step four the step advances to panel read, 0101.
// - Panel read loads one core character and rewrites it unchanged.
// - Panel write, 0110, stores the six-bit character into core.
// - Partition view shows partition number up to 19, rightmost rows.
// - Single-state mode executes one positioning function state per advance, then halts.
// - Function bump mode adds one to the function counter only.
// - Phase bump mode adds one to the step counter and clears the sub-step.
// - Partition bump mode adds one to the partition counter only.
module mpca_panel #(
  parameter int ADDR_W = 12,
  parameter int DEBOUNCE_CYCLES = mpca_pkg::DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [2:0] mode_sel,
  input wire logic [2:0] view_sel,
  input wire logic [5:0] data_sw,
  input wire logic advance_btn,
  input wire logic load_btn,
  input wire logic sys_reset_btn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [15:0] addr_lamps,
  output logic [5:0] data_lamps,
  output logic [3:0] func_lamps,
  output logic [3:0] step_lamps
);

  localparam int DEPTH = 1 << ADDR_W;

  logic advance_p, load_p, sysrst_p;
  logic [3:0] func_q, func_d, step_q, step_d;
  logic [2:0] sub_q, sub_d;
  logic [4:0] part_q, part_d;
  logic [15:0] ptr_q, ptr_d;
  logic [5:0] char_q, char_d;
  logic run_q, run_d;
  logic [15:0] alamp_q, alamp_d;
  logic [5:0] dlamp_q, dlamp_d;
  logic [3:0] flamp_q, flamp_d, slamp_q, slamp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [5:0] mem [0:DEPTH-1];
  logic mem_we;
  logic [ADDR_W-1:0] mem_idx;
  logic [5:0] mem_rd;
  logic [5:0] mem_wdata;
  logic [5:0] dlamp_src;
  logic [31:0] status_word;
  logic halted;
  logic [5:0] view_bus;
  logic [15:0] view_addr;
  logic [3:0] part_tens, part_ones;
  mpca_pkg::mpca_mode_type mode;

  ////////////////////////////////////////////////////////////////////////////

  // Every pushbutton passes the same synchroniser and debouncer, so a held
  // or bouncing contact still gives exactly one action per press.
  mpca_button #(.CYCLES(DEBOUNCE_CYCLES)) u_advance (
    .mclk(mclk),
    .srst(srst),
    .btn(advance_btn),
    .press(advance_p)
  );

  mpca_button #(.CYCLES(DEBOUNCE_CYCLES)) u_load (
    .mclk(mclk),
    .srst(srst),
    .btn(load_btn),
    .press(load_p)
  );

  mpca_button #(.CYCLES(DEBOUNCE_CYCLES)) u_sysrst (
    .mclk(mclk),
    .srst(srst),
    .btn(sys_reset_btn),
    .press(sysrst_p)
  );

  ////////////////////////////////////////////////////////////////////////////

  // The pointer holds four BCD digits; core is indexed by their binary value.
  // Addresses beyond the core size wrap, as only the low index bits are kept.
  function automatic logic [13:0] bcd_value(input logic [15:0] d);
    logic [13:0] v;
    v = 14'({10'h000, d[15:12]} * 14'h3E8);
    v = 14'(v + {10'h000, d[11:8]} * 14'h064);
    v = 14'(v + {10'h000, d[7:4]} * 14'h00A);
    v = 14'(v + {10'h000, d[3:0]});
    return v;
  endfunction : bcd_value

  assign mode = mpca_pkg::mpca_mode_type'(mode_sel);
  // The central logic only runs freely when software allows it in normal
  // mode; every other mode holds it stopped between advances.
  assign halted = !(run_q && (mode == mpca_pkg::MPCA_MODE_NORMAL));
  assign mem_idx = ADDR_W'(bcd_value(ptr_q));
  assign mem_rd = mem[mem_idx];
  // The partition number shows as two BCD rows, tens then ones.
  assign part_tens = (part_q >= mpca_pkg::PART_TEN) ? 4'h1 : 4'h0;
  assign part_ones = 4'(part_q - ((part_q >= mpca_pkg::PART_TEN) ?
                     mpca_pkg::PART_TEN : 5'h00));
  // Status fields: function, step, partition, sub-step and halted flag.
  assign status_word = {11'h000, halted, 1'b0, sub_q, 3'h0, part_q, step_q,
                        func_q};

  ////////////////////////////////////////////////////////////////////////////

  // View route bus and address lamp source for each selector position.
  // The pointer, partition and state views put a register on the route bus,
  // which a load then ORs into the character pair; other views put zero.
  always_comb begin
    view_bus = 6'h00;
    view_addr = 16'h0000;
    case (view_sel)
      mpca_pkg::VIEW_BASE_CHAR: begin
        view_bus = 6'h00;
        view_addr = 16'h0000;
      end
      mpca_pkg::VIEW_POINTER: begin
        view_addr = ptr_q;
        view_bus = {2'b00, step_q};
      end
      mpca_pkg::VIEW_PARTITION: begin
        view_addr = {8'h00, part_tens, part_ones};
        view_bus = {2'b00, func_q};
      end
      mpca_pkg::VIEW_STATE: begin
        view_addr = {func_q, step_q, 5'h00, sub_q};
        view_bus = {3'b000, sub_q};
      end
      default: begin
        view_bus = 6'h00;
        view_addr = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  // Panel state next values.
  always_comb begin
    func_d = func_q;
    step_d = step_q;
    sub_d = sub_q;
    part_d = part_q;
    ptr_d = ptr_q;
    char_d = char_q;
    run_d = run_q;
    mem_we = 1'b0;
    mem_wdata = char_q;
    // Only the control word is writable; writes elsewhere are ignored.
    if (reg_wr && reg_addr == mpca_pkg::REG_CTRL) begin
      run_d = reg_wdata[mpca_pkg::CTRL_RUN_BIT];
    end
    // A system reset press outranks a load and a load outranks an advance,
    // so coinciding pulses never mix their effects.
    if (sysrst_p) begin
      func_d = mpca_pkg::FUNC_SWITCH;
      step_d = mpca_pkg::STEP_RESET_LANDING;
      sub_d = mpca_pkg::SUB_NOP;
      part_d = 5'h00;
      ptr_d = 16'h0000;
      char_d = 6'h00;
      run_d = mpca_pkg::CTRL_RESET;
    end else if (load_p && halted) begin
      char_d = data_sw | view_bus;
    end else if (advance_p && halted) begin
      case (mode)
        mpca_pkg::MPCA_MODE_FUNCTION_BUMP: begin
          // Function and step counters wrap at their own width; partition wraps after PART_MAX.
          func_d = func_q + 4'h1;
        end
        mpca_pkg::MPCA_MODE_PHASE_BUMP: begin
          step_d = step_q + 4'h1;
          sub_d = mpca_pkg::SUB_NOP;
        end
        mpca_pkg::MPCA_MODE_PARTITION_BUMP: begin
          part_d = (part_q == mpca_pkg::PART_MAX) ? 5'h00 :
                   part_q + 5'h01;
        end
        mpca_pkg::MPCA_MODE_SINGLE_STATE: begin
          // One state per press; the block stays halted afterwards.
          if (func_q == mpca_pkg::FUNC_POSITION) begin
            case (step_q)
              mpca_pkg::STEP_ADDRESS_LOAD: begin
                // Sub-step n fills digit four minus n, the top digit first.
                case (sub_q)
                  3'h1: ptr_d[15:12] = char_q[3:0];
                  3'h2: ptr_d[11:8] = char_q[3:0];
                  3'h3: ptr_d[7:4] = char_q[3:0];
                  3'h4: ptr_d[3:0] = char_q[3:0];
                  default: ptr_d = ptr_q;
                endcase
                if (sub_q == mpca_pkg::SUB_DIGIT_LAST) begin
                  step_d = mpca_pkg::STEP_PANEL_READ;
                  sub_d = mpca_pkg::SUB_NOP;
                end else begin
                  sub_d = sub_q + 3'h1;
                end
              end
              mpca_pkg::STEP_PANEL_READ: begin
                // The pointer is not stepped; the operator reloads it to
                // reach another location.
                char_d = mem_rd;
                mem_we = 1'b1;
                mem_wdata = mem_rd;
              end
              mpca_pkg::STEP_PANEL_WRITE: begin
                mem_we = 1'b1;
              end
              default: begin
                func_d = func_q;
              end
            endcase
          end
        end
        default: begin
          func_d = func_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      func_q <= mpca_pkg::FUNC_SWITCH;
      step_q <= mpca_pkg::STEP_RESET_LANDING;
      sub_q <= mpca_pkg::SUB_NOP;
      part_q <= 5'h00;
      ptr_q <= 16'h0000;
      char_q <= 6'h00;
      run_q <= mpca_pkg::CTRL_RESET;
    end else begin
      func_q <= func_d;
      step_q <= step_d;
      sub_q <= sub_d;
      part_q <= part_d;
      ptr_q <= ptr_d;
      char_q <= char_d;
      run_q <= run_d;
    end
  end

  // A panel read writes the fetched character straight back, as a core read
  // would need, so core keeps its contents. Core has no reset, so reading a
  // location before any write returns unknown data.
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Data lamp source; the base view shows the character pair itself, every
  // other view reads the route bus and leaves the pair untouched.
  always_comb begin
    dlamp_src = view_bus;
    if (view_sel == mpca_pkg::VIEW_BASE_CHAR) begin
      dlamp_src = char_q;
    end
  end

  // Lamp drivers; dark while the central logic runs.
  always_comb begin
    alamp_d = 16'h0000;
    dlamp_d = 6'h00;
    flamp_d = 4'h0;
    slamp_d = 4'h0;
    if (halted) begin
      alamp_d = view_addr;
      flamp_d = func_q;
      slamp_d = step_q;
      dlamp_d = dlamp_src;
    end
  end

  // Lamps are registered, so they trail the selected state by one cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      alamp_q <= 16'h0000;
      dlamp_q <= 6'h00;
      flamp_q <= 4'h0;
      slamp_q <= 4'h0;
    end else begin
      alamp_q <= alamp_d;
      dlamp_q <= dlamp_d;
      flamp_q <= flamp_d;
      slamp_q <= slamp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Register read port: data stand only in the cycle after the strobe.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        mpca_pkg::REG_CTRL: rdata_d = {31'h0000_0000, run_q};
        mpca_pkg::REG_STATUS: begin
          rdata_d = status_word;
        end
        mpca_pkg::REG_POINTER: rdata_d = {16'h0000, ptr_q};
        mpca_pkg::REG_CHAR: rdata_d = {26'h000_0000, char_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign addr_lamps = alamp_q;
  assign data_lamps = dlamp_q;
  assign func_lamps = flamp_q;
  assign step_lamps = slamp_q;

endmodule : mpca_panel

// ===== src/mpca_pkg.sv
// Constants and types shared by the maintenance panel core access block.
package mpca_pkg;

  // Function and step codes of the processor state counters.
  localparam logic [3:0] FUNC_POSITION = 4'hF;
  localparam logic [3:0] FUNC_SWITCH = 4'h3;
  localparam logic [3:0] STEP_RESET_LANDING = 4'h2;
  localparam logic [3:0] STEP_ADDRESS_LOAD = 4'h4;
  localparam logic [3:0] STEP_PANEL_READ = 4'h5;
  localparam logic [3:0] STEP_PANEL_WRITE = 4'h6;

  // Sub-step counter in the address load state.
  localparam logic [2:0] SUB_NOP = 3'h0;
  localparam logic [2:0] SUB_DIGIT_LAST = 3'h4;

  // Partition counter wraps after its highest number.
  localparam logic [4:0] PART_MAX = 5'h13;
  localparam logic [4:0] PART_TEN = 5'h0A;

  // Display selector positions.
  localparam logic [2:0] VIEW_BASE_CHAR = 3'h0;
  localparam logic [2:0] VIEW_POINTER = 3'h1;
  localparam logic [2:0] VIEW_PARTITION = 3'h2;
  localparam logic [2:0] VIEW_STATE = 3'h3;

  // Mode selector positions, Gray coded from normal towards the bump modes.
  typedef enum logic [2:0] {
    MPCA_MODE_NORMAL = 3'b000,
    MPCA_MODE_NO_SWITCH = 3'b001,
    MPCA_MODE_NO_FETCH = 3'b011,
    MPCA_MODE_STOP_INSTR = 3'b010,
    MPCA_MODE_SINGLE_STATE = 3'b110,
    MPCA_MODE_FUNCTION_BUMP = 3'b111,
    MPCA_MODE_PHASE_BUMP = 3'b101,
    MPCA_MODE_PARTITION_BUMP = 3'b100
  } mpca_mode_type;

  // Register port map, byte addresses of 32-bit words.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_POINTER = 4'h8;
  localparam logic [3:0] REG_CHAR = 4'hC;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;

  // Pushbutton debounce time and the cycle count derived from the clock.
  localparam int DEBOUNCE_US = 5000;
  localparam int CLK_MHZ = 200;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

endpackage : mpca_pkg

// ===== test/mpca_op.sv
// Operator model: selector switches, data switches and pushbuttons.
module mpca_op (
  input wire logic mclk,
  output logic [2:0] mode_sel,
  output logic [2:0] view_sel,
  output logic [5:0] data_sw,
  output logic advance_btn,
  output logic load_btn,
  output logic sys_reset_btn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mode_sel = 3'h0;
    view_sel = 3'h0;
    data_sw = 6'h0;
    advance_btn = 1'b0;
    load_btn = 1'b0;
    sys_reset_btn = 1'b0;
  end
  task automatic sw(input logic [2:0] m, v, input logic [5:0] d);
    @(posedge mclk);
    mode_sel <= m;
    view_sel <= v;
    data_sw <= d;
  endtask : sw
  // Held and released well past the debounce time, so every press counts.
  task automatic push(input int k);
    @(posedge mclk);
    advance_btn <= (k == 0);
    load_btn <= (k == 1);
    sys_reset_btn <= (k == 2);
    repeat (12) @(posedge mclk);
    advance_btn <= 1'b0;
    load_btn <= 1'b0;
    sys_reset_btn <= 1'b0;
    repeat (12) @(posedge mclk);
    #1;
  endtask : push
endmodule : mpca_op

// ===== test/mpca_panel_sva.sv
// Port assertions for the maintenance panel core access block.
module mpca_panel_sva #(
  parameter int DEBOUNCE_CYCLES = mpca_pkg::DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [2:0] mode_sel,
  input wire logic [2:0] view_sel,
  input wire logic sys_reset_btn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [15:0] addr_lamps,
  input wire logic [5:0] data_lamps,
  input wire logic [3:0] func_lamps,
  input wire logic [3:0] step_lamps
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  sequence run_started;
    reg_wr && reg_addr == mpca_pkg::REG_CTRL && reg_wdata[0]
      && mode_sel == 3'h0 ##1 mode_sel == 3'h0 [*3];
  endsequence
  // Three cycles let the registered lamps catch up with a mode change.
  sequence held(logic [2:0] m);
    mode_sel == m [*3];
  endsequence
  sequence view_held(logic [2:0] v);
    view_sel == v [*3];
  endsequence
  ////////////////////////////////////////
  chk_run_dark: assert property (run_started |-> addr_lamps == 16'h0
    && data_lamps == 6'h0 && func_lamps == 4'h0 && step_lamps == 4'h0)
    else $error("lamps lit while running");
  chk_func_bump: assert property (held(3'b111) |-> $stable(step_lamps)
    && (func_lamps == $past(func_lamps)
    || func_lamps == $past(func_lamps) + 4'h1))
    else $error("function bump changed more than the function count");
  chk_phase_bump: assert property (held(3'b101) |-> $stable(func_lamps)
    && (step_lamps == $past(step_lamps)
    || step_lamps == $past(step_lamps) + 4'h1))
    else $error("phase bump changed more than the step count");
  chk_part_only: assert property (held(3'b100) |->
    $stable(func_lamps) && $stable(step_lamps))
    else $error("partition bump touched function or step");
  chk_load_to_read: assert property (held(3'b110) |->
    $stable(step_lamps) || ($past(step_lamps) == 4'h4
    && step_lamps == 4'h5 && func_lamps == 4'hF)
    || (step_lamps == 4'h2 && func_lamps == 4'h3))
    else $error("single state step change other than load to read");
  chk_part_bcd: assert property (view_held(3'h2) |->
    addr_lamps[7:4] <= 4'h1 && addr_lamps[3:0] <= 4'h9)
    else $error("partition lamps out of range");
  chk_pointer_view: assert property (view_held(3'h1) |->
    data_lamps == {2'h0, step_lamps} && addr_lamps[15:12] <= 4'h9
    && addr_lamps[3:0] <= 4'h9)
    else $error("pointer view contents wrong");
  // Only a short debounce lets the landing state appear in this window.
  if (DEBOUNCE_CYCLES <= 8) begin : g_short
    chk_sys_reset: assert property ($rose(sys_reset_btn) ##1
      sys_reset_btn [*8] |-> ##[1:24] func_lamps == 4'h3 && step_lamps == 4'h2)
      else $error("system reset did not land in switch step two");
  end
endmodule : mpca_panel_sva

bind mpca_panel mpca_panel_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
  i_mpca_panel_sva (
  .mclk(mclk),
  .srst(srst),
  .mode_sel(mode_sel),
  .view_sel(view_sel),
  .sys_reset_btn(sys_reset_btn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .addr_lamps(addr_lamps),
  .data_lamps(data_lamps),
  .func_lamps(func_lamps),
  .step_lamps(step_lamps)
);

// ===== test/mpca_panel_tb_top.sv
// Self-checking bench for the maintenance panel core access block.
module mpca_panel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] NRM = 3'b000;
  localparam logic [2:0] SS = mpca_pkg::MPCA_MODE_SINGLE_STATE;
  localparam logic [2:0] FB = mpca_pkg::MPCA_MODE_FUNCTION_BUMP;
  localparam logic [2:0] PB = mpca_pkg::MPCA_MODE_PHASE_BUMP;
  localparam logic [2:0] XB = mpca_pkg::MPCA_MODE_PARTITION_BUMP;
  localparam logic [2:0] B = mpca_pkg::VIEW_BASE_CHAR;
  localparam logic [2:0] P = mpca_pkg::VIEW_POINTER;
  logic mclk, srst, reg_wr, reg_rd, advance_btn, load_btn, sys_reset_btn;
  logic [2:0] mode_sel, view_sel;
  logic [5:0] data_sw, data_lamps, ch;
  logic [3:0] reg_addr, func_lamps, step_lamps, dig;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [15:0] addr_lamps, ptr;
  int mismatches, checked;
  mpca_panel #(.DEBOUNCE_CYCLES(4)) i_mpca_panel (
    .mclk(mclk),
    .srst(srst),
    .mode_sel(mode_sel),
    .view_sel(view_sel),
    .data_sw(data_sw),
    .advance_btn(advance_btn),
    .load_btn(load_btn),
    .sys_reset_btn(sys_reset_btn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .addr_lamps(addr_lamps),
    .data_lamps(data_lamps),
    .func_lamps(func_lamps),
    .step_lamps(step_lamps)
  );
  mpca_op i_mpca_op (
    .mclk(mclk),
    .mode_sel(mode_sel),
    .view_sel(view_sel),
    .data_sw(data_sw),
    .advance_btn(advance_btn),
    .load_btn(load_btn),
    .sys_reset_btn(sys_reset_btn)
  );
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] bcd2(input int p);
    return {4'(p / 10), 4'(p % 10)};
  endfunction : bcd2
  function automatic logic [31:0] stat(input logic [3:0] f, s,
                                       input logic [2:0] q);
    return {11'h0, 1'b1, 1'b0, q, 8'h0, s, f};
  endfunction : stat
  task automatic check(input string n, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write
  // Read data stand only in the cycle after the strobe.
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
    #1 check("rdata idle", reg_rdata, 32'h0);
  endtask : reg_read
  task automatic st(input logic [3:0] f, s, input logic [2:0] q);
    reg_read(mpca_pkg::REG_STATUS, rd);
    check("status", rd, stat(f, s, q));
  endtask : st
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("ERROR watchdog expected finish seen hang");
    test_done();
  end
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ptr = 16'h0;
    void'($urandom(5));
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    st(4'h3, 4'h2, 3'h0);
    check("lamps", {24'h0, func_lamps, step_lamps}, 32'h32);
    dig = 4'($urandom) | 4'h1;
    reg_write(dig, 32'hFFFF_FFFF);
    reg_read(dig, rd);
    check("unmapped", rd, 32'h0);
    reg_read(mpca_pkg::REG_CTRL, rd);
    check("write refused", rd, 32'h0);
    i_mpca_op.sw(NRM, P, 6'h3F);
    rd = $urandom;
    reg_write(mpca_pkg::REG_CTRL, rd | 32'h1);
    i_mpca_op.push(1);
    check("dark", {2'h0, addr_lamps, data_lamps, func_lamps, step_lamps},
      32'h0);
    reg_write(mpca_pkg::REG_CTRL, rd & 32'hFFFF_FFFE);
    reg_read(mpca_pkg::REG_CHAR, rd);
    check("char kept", rd, 32'h0);
    $display("test reset and run done");
    repeat (4) begin
      ch = 6'($urandom);
      i_mpca_op.sw(NRM, B, ch);
      i_mpca_op.push(1);
      check("char lamps", {26'h0, data_lamps}, {26'h0, ch});
    end
    i_mpca_op.sw(NRM, P, 6'h30);
    i_mpca_op.push(1);
    check("view bus", {26'h0, data_lamps}, 32'h2);
    reg_read(mpca_pkg::REG_CHAR, rd);
    check("or load", rd, 32'h32);
    $display("test load done");
    i_mpca_op.sw(XB, mpca_pkg::VIEW_PARTITION, 6'h0);
    for (int i = 1; i <= 20; i++) begin
      i_mpca_op.push(0);
      check("part", {24'h0, addr_lamps[7:0]}, {24'h0, bcd2(i % 20)});
    end
    i_mpca_op.sw(FB, B, 6'h0);
    repeat (12) i_mpca_op.push(0);
    i_mpca_op.sw(PB, B, 6'h0);
    repeat (2) i_mpca_op.push(0);
    check("state", {24'h0, func_lamps, step_lamps}, 32'hF4);
    $display("test bump modes done");
    i_mpca_op.sw(SS, B, 6'h0);
    i_mpca_op.push(0);
    st(4'hF, 4'h4, 3'h1);
    for (int d = 3; d >= 0; d--) begin
      dig = 4'($urandom_range(9));
      ptr[d*4+:4] = dig;
      i_mpca_op.sw(SS, B, {2'h0, dig});
      i_mpca_op.push(1);
      i_mpca_op.push(0);
      if (d > 0) st(4'hF, 4'h4, 3'(5 - d));
    end
    st(4'hF, 4'h5, 3'h0);
    reg_read(mpca_pkg::REG_POINTER, rd);
    check("pointer", rd, {16'h0, ptr});
    i_mpca_op.sw(SS, P, 6'h0);
    repeat (3) @(posedge mclk);
    #1 check("ptr lamps", {16'h0, addr_lamps}, {16'h0, ptr});
    i_mpca_op.sw(SS, mpca_pkg::VIEW_STATE, 6'h0);
    repeat (3) @(posedge mclk);
    #1 check("state view", {addr_lamps, 10'h0, data_lamps},
      32'hF500_0000);
    $display("test address load done");
    i_mpca_op.sw(PB, B, 6'h0);
    i_mpca_op.push(0);
    ch = 6'($urandom);
    i_mpca_op.sw(SS, B, ch);
    i_mpca_op.push(1);
    i_mpca_op.push(0);
    check("write", {24'h0, func_lamps, step_lamps}, 32'hF6);
    i_mpca_op.sw(PB, B, 6'h0);
    repeat (15) i_mpca_op.push(0);
    i_mpca_op.sw(SS, B, 6'h0);
    i_mpca_op.push(1);
    repeat (2) begin
      i_mpca_op.push(0);
      check("core read", {26'h0, data_lamps}, {26'h0, ch});
    end
    i_mpca_op.sw(FB, B, 6'h0);
    i_mpca_op.push(0);
    check("left", {28'h0, func_lamps}, 32'h0);
    i_mpca_op.sw(NRM, B, 6'h0);
    i_mpca_op.push(2);
    st(4'h3, 4'h2, 3'h0);
    reg_read(mpca_pkg::REG_POINTER, rd);
    check("ptr reset", rd, 32'h0);
    $display("test core access done");
    test_done();
  end
endmodule : mpca_panel_tb_top
